//--- core/i2cs_slave.sv
// i2c slave-only interface with 7-bit address and bus time-out
// assumes open-drain pins resolved outside and a free-running sub clock
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - START is SDA falling while SCL high
// - START sets bus busy flag
// - compare 7-bit address, interrupt on match
// - eighth bit captured as read/write flag
// - acknowledge matched address on ninth clock
// - address match sets match flag
// - one interrupt, three causes, flags tell apart
// - hold SCL low until data access
// - data bytes are 8 bits, MSB first
// - receiver drives ack_to_send on ninth clock
// - no master ack: record, release SDA
// - data register holds received and sent bytes
// - counter starts on match, SCL fall clears
// - time-out when gap exceeds selected period
// - STOP halts the time-out counter
// - overflow: stop, disable, flag, interrupt
// - time-out resets status, keeps other registers
// - period is (select+1) times 32 sub clocks
// - software may clear the time-out flag
// - complete flag low while shifting, set after
// - STOP clears bus busy flag
module i2cs_slave
   import i2cs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // i2c pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // time-out clock source
   input wire logic sub_clk,
   // interrupt
   output logic i2c_irq
);
   import i2cs_pkg::*;

   logic scl_m, scl_s, scl_p;
   logic sda_m, sda_s, sda_p;
   logic sub_m, sub_s, sub_p;
   logic scl_rise, scl_fall, start_det, stop_det, sub_rise;
   i2cs_state_t st_r;
   logic [2:0] bit_r;
   logic [7:0] shift_r, shift_nxt;
   logic ack_on_r, scl_oe_r, sda_oe_r, pin_low_r;
   logic cmpl_r, match_r, busy_r, txsel_r, ack_to_send_r, rw_r, wake_r, ack_received_r;
   logic [7:0] data_r, own_r, mode_r, rdata_r;
   logic to_en_r, to_flag_r, to_run_r;
   logic [TO_SEL_W-1:0] to_sel_r, tcnt_r;
   logic [PRESC_W-1:0] presc_r;
   logic active, live, addr_ok, addr_hit, rx_done, tx_ack_smp;
   logic hold_release, timeout_evt, irq_r;
   logic wr_data, rd_data, wr_stat, wr_toc;

   // two-stage synchronisers, then a previous-value stage for edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
         sub_m <= 1'b0;
         sub_s <= 1'b0;
         sub_p <= 1'b0;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_p <= sda_s;
         sub_m <= sub_clk;
         sub_s <= sub_m;
         sub_p <= sub_s;
      end
   end

   // bus conditions; only the master makes START, we only watch
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
   assign sub_rise = sub_s & ~sub_p;

   // register strobes
   assign wr_data = reg_wr && (reg_addr == ADR_DATA);
   assign rd_data = reg_rd && (reg_addr == ADR_DATA);
   assign wr_stat = reg_wr && (reg_addr == ADR_STAT);
   assign wr_toc = reg_wr && (reg_addr == ADR_TOC);

   // protocol events
   assign active = mode_r[MC_EN] && (mode_r[MC_MODE_LO+2:MC_MODE_LO] == MODE_I2C);
   assign live = active && !timeout_evt && !start_det && !stop_det;
   assign shift_nxt = {shift_r[6:0], sda_s};
   assign addr_ok = (shift_nxt[7:1] == own_r[7:1]);
   assign addr_hit = live && (st_r == ST_ADDR) && scl_rise && (bit_r == 3'h7) && addr_ok;
   assign rx_done = live && (st_r == ST_RX) && scl_rise && (bit_r == 3'h7);
   assign tx_ack_smp = live && (st_r == ST_TACK) && scl_rise;
   // write releases a transmitter, a dummy read releases a receiver
   assign hold_release = live && (st_r == ST_HOLD) &&
                         ((wr_data && txsel_r) || (rd_data && !txsel_r));
   // fires on the tick that completes (select+1) prescaler wraps
   assign timeout_evt = to_run_r && to_en_r && !scl_fall && sub_rise &&
                        (presc_r == PRESC_LAST) && (tcnt_r == to_sel_r);

   // byte engine: shifting, acknowledge and clock stretching
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         ack_on_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (timeout_evt || !active) begin
         st_r <= ST_IDLE;
         bit_r <= 3'h0;
         ack_on_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (start_det) begin
         st_r <= ST_ADDR;
         bit_r <= 3'h0;
         ack_on_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (stop_det) begin
         st_r <= ST_IDLE;
         ack_on_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               bit_r <= 3'h0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_r <= shift_nxt;
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     st_r <= addr_ok ? ST_AACK : ST_IDLE;
                  end
               end
            end
            ST_AACK, ST_RACK: begin
               if (scl_fall && !ack_on_r) begin
                  ack_on_r <= 1'b1;
                  // address ack is always low; data ack follows ack_to_send
                  sda_oe_r <= (st_r == ST_AACK) ? 1'b1 : !ack_to_send_r;
               end else if (scl_fall) begin
                  ack_on_r <= 1'b0;
                  sda_oe_r <= 1'b0;
                  scl_oe_r <= 1'b1;
                  st_r <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (hold_release) begin
                  scl_oe_r <= 1'b0;
                  bit_r <= 3'h0;
                  if (txsel_r) begin
                     shift_r <= reg_wdata;
                     sda_oe_r <= !reg_wdata[7];
                     st_r <= ST_TX;
                  end else begin
                     st_r <= ST_RX;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_r <= shift_nxt;
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     st_r <= ST_RACK;
                  end
               end
            end
            ST_TX: begin
               // next bit goes out while SCL is low
               if (scl_fall) begin
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     sda_oe_r <= 1'b0;
                     st_r <= ST_TACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sda_oe_r <= !shift_r[6];
                  end
               end
            end
            ST_TACK: begin
               if (scl_fall) begin
                  if (!ack_received_r) begin
                     scl_oe_r <= 1'b1;
                     st_r <= ST_HOLD;
                  end else begin
                     st_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // open-drain drive level is always low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_low_r <= 1'b0;
      end else begin
         pin_low_r <= 1'b0;
      end
   end

   // status_control_1; a time-out restores its power-on values
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmpl_r <= CMPL_POR;
         match_r <= 1'b0;
         busy_r <= 1'b0;
         txsel_r <= 1'b0;
         ack_to_send_r <= 1'b0;
         rw_r <= 1'b0;
         wake_r <= 1'b0;
         ack_received_r <= ACK_RECEIVED_POR;
      end else if (timeout_evt) begin
         cmpl_r <= CMPL_POR;
         match_r <= 1'b0;
         busy_r <= 1'b0;
         txsel_r <= 1'b0;
         ack_to_send_r <= 1'b0;
         rw_r <= 1'b0;
         wake_r <= 1'b0;
         ack_received_r <= ACK_RECEIVED_POR;
      end else begin
         if (start_det) begin
            busy_r <= 1'b1;
         end else if (stop_det) begin
            busy_r <= 1'b0;
         end
         if (addr_hit) begin
            match_r <= 1'b1;
            rw_r <= shift_nxt[0];
         end else if (start_det || hold_release) begin
            match_r <= 1'b0;
         end
         // set wins: completion and clearing never share a cycle anyway
         if (rx_done || tx_ack_smp) begin
            cmpl_r <= 1'b1;
         end else if (start_det || hold_release) begin
            cmpl_r <= 1'b0;
         end
         if (tx_ack_smp) begin
            ack_received_r <= sda_s;
         end
         if (wr_stat) begin
            txsel_r <= reg_wdata[SC_TXSEL];
            ack_to_send_r <= reg_wdata[SC_ACK_TO_SEND];
            wake_r <= reg_wdata[SC_WAKE];
         end
      end
   end

   // data, own address and mode registers survive a time-out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_r <= DATA_POR;
         own_r <= OWN_POR;
         mode_r <= MODE_POR;
      end else begin
         if (rx_done) begin
            data_r <= shift_nxt;
         end else if (wr_data) begin
            data_r <= reg_wdata;
         end
         if (reg_wr && (reg_addr == ADR_OWN)) begin
            own_r <= reg_wdata;
         end
         if (reg_wr && (reg_addr == ADR_MODE)) begin
            mode_r <= reg_wdata;
         end
      end
   end

   // time-out control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         to_en_r <= TOC_POR[TO_EN];
         to_flag_r <= TOC_POR[TO_FLAG];
         to_sel_r <= TOC_POR[TO_SEL_W-1:0];
      end else begin
         if (timeout_evt) begin
            to_en_r <= 1'b0;
         end else if (wr_toc) begin
            to_en_r <= reg_wdata[TO_EN];
         end
         // hardware set beats a software clear in the same cycle
         if (timeout_evt) begin
            to_flag_r <= 1'b1;
         end else if (wr_toc) begin
            to_flag_r <= reg_wdata[TO_FLAG];
         end
         if (wr_toc) begin
            to_sel_r <= reg_wdata[TO_SEL_W-1:0];
         end
      end
   end

   // time-out counter: prescaler by 32, then period ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         to_run_r <= 1'b0;
         presc_r <= '0;
         tcnt_r <= '0;
      end else begin
         if (addr_hit) begin
            to_run_r <= 1'b1;
         end else if (stop_det || timeout_evt) begin
            to_run_r <= 1'b0;
         end
         if (scl_fall || !to_run_r || !to_en_r) begin
            presc_r <= '0;
            tcnt_r <= '0;
         end else if (sub_rise) begin
            presc_r <= presc_r + 5'h01;
            if (presc_r == PRESC_LAST) begin
               tcnt_r <= tcnt_r + 6'h01;
            end
         end
      end
   end

   // one interrupt pulse for all three causes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= addr_hit || rx_done || tx_ack_smp || timeout_evt;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADR_DATA: rdata_r <= data_r;
            ADR_OWN: rdata_r <= own_r;
            ADR_MODE: rdata_r <= mode_r;
            ADR_STAT: rdata_r <= {cmpl_r, match_r, busy_r, txsel_r,
                                  ack_to_send_r, rw_r, wake_r, ack_received_r};
            ADR_TOC: rdata_r <= {to_en_r, to_flag_r, to_sel_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;
   assign scl_o = pin_low_r;
   assign sda_o = pin_low_r;
   assign scl_oe = scl_oe_r;
   assign sda_oe = sda_oe_r;
   assign i2c_irq = irq_r;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_start_busy: assert property (start_det && !timeout_evt |=> busy_r)
      else $error("start did not set busy");
   a_stop_free: assert property (stop_det && !timeout_evt |=> !busy_r)
      else $error("stop did not clear busy");
   a_match_irq: assert property (addr_hit |=> match_r && i2c_irq)
      else $error("match without flag and interrupt");
   a_rw_capture: assert property (addr_hit |=> rw_r == $past(sda_s))
      else $error("read/write bit not captured");
   // ack is pulled on the first fall after a matched address byte
   a_addr_ack: assert property (st_r == ST_AACK && live && scl_fall && !ack_on_r
      |=> sda_oe)
      else $error("address not acknowledged");
   a_hold_release: assert property (hold_release |=> !scl_oe ##0 cmpl_r == 1'b0)
      else $error("scl not released by data access");
   a_rx_store: assert property (rx_done |=> data_r == $past(shift_nxt) && cmpl_r)
      else $error("received byte not stored");
   a_tx_msb: assert property (hold_release && txsel_r |=> sda_oe == !$past(reg_wdata[7]))
      else $error("first transmit bit wrong");
   a_timeout_eff: assert property (timeout_evt |=> to_flag_r && !to_en_r && i2c_irq
      && !busy_r && cmpl_r && ack_received_r && st_r == ST_IDLE && !scl_oe)
      else $error("time-out effects missing");
   a_fall_clear: assert property (scl_fall |=> presc_r == 5'h00 && tcnt_r == 6'h00)
      else $error("scl fall did not clear counter");
   a_stop_halt: assert property (stop_det && !addr_hit |=> !to_run_r)
      else $error("stop did not halt time-out");

   c_match: cover property (addr_hit);
   c_rx_byte: cover property (rx_done);
   c_tx_ack: cover property (tx_ack_smp && !sda_s);
   c_timeout: cover property (timeout_evt);
endmodule

`default_nettype wire

//--- shared/i2cs_pkg.sv
// constants for the i2c slave with bus time-out
// assumes an 8-bit register port with a 3-bit word address
package i2cs_pkg;
   // register word addresses
   localparam logic [2:0] ADR_DATA = 3'h0;
   localparam logic [2:0] ADR_OWN = 3'h1;
   localparam logic [2:0] ADR_MODE = 3'h2;
   localparam logic [2:0] ADR_STAT = 3'h3;
   localparam logic [2:0] ADR_TOC = 3'h4;
   // status_control_1 field positions
   localparam int SC_CMPL = 7;
   localparam int SC_MATCH = 6;
   localparam int SC_BUSY = 5;
   localparam int SC_TXSEL = 4;
   localparam int SC_ACK_TO_SEND = 3;
   localparam int SC_RW = 2;
   localparam int SC_WAKE = 1;
   localparam int SC_ACK_RECEIVED = 0;
   // timeout_control_register field positions
   localparam int TO_EN = 7;
   localparam int TO_FLAG = 6;
   localparam int TO_SEL_W = 6;
   // mode_control_0 fields
   localparam int MC_EN = 1;
   localparam int MC_MODE_LO = 5;
   localparam logic [2:0] MODE_I2C = 3'h6;
   // reset values
   localparam logic [7:0] DATA_POR = 8'h00;
   localparam logic [7:0] OWN_POR = 8'h00;
   localparam logic [7:0] MODE_POR = 8'h00;
   localparam logic [7:0] TOC_POR = 8'h00;
   localparam logic CMPL_POR = 1'b1;
   localparam logic ACK_RECEIVED_POR = 1'b1;
   // time-out prescaler: sub clock divided by 32
   localparam int PRESC_W = 5;
   localparam logic [PRESC_W-1:0] PRESC_LAST = 5'h1f;
   // protocol states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_AACK = 8'h04,
      ST_HOLD = 8'h08,
      ST_RX = 8'h10,
      ST_RACK = 8'h20,
      ST_TX = 8'h40,
      ST_TACK = 8'h80
   } i2cs_state_t;
endpackage

//--- verif/i2cs_master.sv
// behavioural i2c bus master facing the slave block
// assumes the bench resolves both wires with pull-ups and feeds them back
`timescale 1ns/1ps
`default_nettype none

module i2cs_master (
   // clock
   input wire logic clk,
   // resolved bus wires
   input wire logic scl,
   input wire logic sda,
   // open-drain pulls, high = drive low
   output logic scl_oe,
   output logic sda_oe,
   // set when the slave stretched beyond the bound
   output logic stuck
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      stuck = 1'b0;
   end

   // half an 800 ns link period at 100 ns system clock
   task automatic half();
      repeat (4) @(posedge clk);
   endtask

   // release scl, then honour stretching with a bounded wait
   task automatic rise();
      int n;
      scl_oe <= 1'b0;
      @(posedge clk);
      for (n = 0; n < 3000 && scl !== 1'b1; n++) @(posedge clk);
      if (n >= 3000) stuck <= 1'b1;
   endtask

   // only this side ever makes a start
   task automatic start();
      sda_oe <= 1'b1;
      half();
      scl_oe <= 1'b1;
   endtask

   // stop, also the way out after a missing acknowledge
   task automatic stop();
      sda_oe <= 1'b1;
      half();
      rise();
      half();
      sda_oe <= 1'b0;
      half();
   endtask

   // one byte out, msb first, acknowledge sampled on the ninth clock
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_oe <= !b[i];
         half();
         rise();
         half();
         scl_oe <= 1'b1;
      end
      sda_oe <= 1'b0;
      half();
      rise();
      ack = sda;
      half();
      scl_oe <= 1'b1;
   endtask

   // one byte in, then answer with ack_bit (1 = no acknowledge)
   task automatic recv_byte(input logic ack_bit, output logic [7:0] b);
      sda_oe <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         half();
         rise();
         repeat (2) @(posedge clk);
         b[i] = sda;
         repeat (2) @(posedge clk);
         scl_oe <= 1'b1;
      end
      sda_oe <= !ack_bit;
      half();
      rise();
      half();
      scl_oe <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the i2c slave with bus time-out
// assumes the behavioural master and pull-ups on both wires
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import i2cs_pkg::*;

   typedef struct {logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] e;} i2cs_row_t;

   logic clk = 1'b0, rst = 1'b1, sub_clk = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic scl_o, scl_oe, sda_o, sda_oe, i2c_irq;
   logic m_scl_oe, m_sda_oe, stuck;
   logic scl_w, sda_w, ack;
   logic [7:0] v;
   int mismatches = 0, total_checks = 0, irq_cnt = 0, n;
   i2cs_row_t rows[16];

   always #50 clk = ~clk;
   always #200 sub_clk = ~sub_clk; // each level two system clocks

   // wired-and of both parties with pull-ups
   assign scl_w = !m_scl_oe && !(scl_oe && !scl_o);
   assign sda_w = !m_sda_oe && !(sda_oe && !sda_o);

   // irq pulses counted, one per cause
   always_ff @(posedge clk) begin
      if (i2c_irq === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   i2cs_slave i_i2cs_slave (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .sub_clk(sub_clk),
      .i2c_irq(i2c_irq));
   i2cs_master i_i2cs_master (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe),
      .sda_oe(m_sda_oe), .stuck(stuck));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // register write, caller sits just after a rising edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // register read, data taken in the one cycle it stands
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask

   task automatic close_out();
      if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      // reset values, access kinds, refused places
      rows = '{'{0, 0, 0, 8'h00}, '{0, 1, 0, 8'h00}, '{0, 2, 0, 8'h00}, '{0, 3, 0, 8'h81},
         '{0, 4, 0, 8'h00}, '{0, 5, 0, 8'h00}, '{1, 3, 8'hff, 8'h9b}, '{1, 3, 8'h00, 8'h81},
         '{1, 5, 8'hff, 8'h00}, '{1, 4, 8'h3f, 8'h3f}, '{1, 4, 8'h40, 8'h40},
         '{1, 4, 8'h80, 8'h80}, '{1, 1, 8'h84, 8'h84}, '{1, 2, 8'hc2, 8'hc2},
         '{1, 0, 8'h5a, 8'h5a}, '{0, 3, 0, 8'h81}};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk("reg", rows[i].e, v);
      end
      // master writes two bytes, time-out armed but never starved
      n = irq_cnt;
      i_i2cs_master.start();
      repeat (8) @(posedge clk);
      rd(ADR_STAT, v);
      chk("busy", 1, v[SC_BUSY]);
      i_i2cs_master.send_byte(8'h84, ack);
      chk("addr_ack", 0, ack);
      repeat (8) @(posedge clk);
      rd(ADR_STAT, v);
      chk("match", 1, v[SC_MATCH]);
      chk("rw_w", 0, v[SC_RW]);
      chk("irq_a", n + 1, irq_cnt);
      chk("stretch", 1, scl_oe);
      rd(ADR_DATA, v);
      repeat (2) @(posedge clk);
      chk("released", 0, scl_oe);
      i_i2cs_master.send_byte(8'ha5, ack);
      chk("rx_ack", 0, ack);
      // the stretch starts three clocks after the fall; a dummy read before it is lost
      repeat (4) @(posedge clk);
      rd(ADR_STAT, v);
      chk("cmpl", 1, v[SC_CMPL]);
      chk("irq_b", n + 2, irq_cnt);
      rd(ADR_DATA, v);
      chk("rx_byte", 8'ha5, v);
      wr(ADR_STAT, 8'h08);
      i_i2cs_master.send_byte(8'h3c, ack);
      chk("rx_nak", 1, ack);
      repeat (4) @(posedge clk);
      rd(ADR_DATA, v);
      chk("rx_byte2", 8'h3c, v);
      i_i2cs_master.stop();
      rd(ADR_STAT, v);
      chk("free", 0, v[SC_BUSY]);
      rd(ADR_TOC, v);
      chk("no_to", 8'h80, v);
      // master reads two bytes, refuses the second
      wr(ADR_STAT, 8'h00);
      i_i2cs_master.start();
      i_i2cs_master.send_byte(8'h85, ack);
      chk("addr_ack2", 0, ack);
      rd(ADR_STAT, v);
      chk("rw_r", 1, v[SC_RW]);
      wr(ADR_STAT, 8'h10);
      wr(ADR_DATA, 8'h3c);
      i_i2cs_master.recv_byte(1'b0, v);
      chk("tx_byte", 8'h3c, v);
      repeat (4) @(posedge clk);
      wr(ADR_DATA, 8'h81);
      i_i2cs_master.recv_byte(1'b1, v);
      chk("tx_byte2", 8'h81, v);
      rd(ADR_STAT, v);
      chk("ack_received", 1, v[SC_ACK_RECEIVED]);
      chk("sda_free", 0, sda_oe);
      i_i2cs_master.stop();
      // foreign address is not acknowledged
      i_i2cs_master.start();
      i_i2cs_master.send_byte(8'h20, ack);
      chk("no_match", 1, ack);
      i_i2cs_master.stop();
      // starved bus: time-out after (0+1)*32 sub clocks
      wr(ADR_STAT, 8'h00);
      i_i2cs_master.start();
      i_i2cs_master.send_byte(8'h84, ack);
      n = irq_cnt;
      for (int k = 0; k < 400 && irq_cnt == n; k++) begin
         @(posedge clk);
         v = k;
      end
      chk("to_late", 1, v >= 8'd100 && v <= 8'd250);
      chk("to_seen", 1, irq_cnt != n);
      repeat (3) @(posedge clk);
      rd(ADR_TOC, v);
      chk("to_reg", 8'h40, v);
      rd(ADR_STAT, v);
      chk("to_stat", 8'h81, v);
      rd(ADR_OWN, v);
      chk("to_own", 8'h84, v);
      chk("to_pins", 0, {scl_oe, sda_oe});
      i_i2cs_master.stop();
      wr(ADR_TOC, 8'h00);
      rd(ADR_TOC, v);
      chk("to_clear", 8'h00, v);
      chk("stuck", 0, stuck);
      close_out();
   end
endmodule
`default_nettype wire
